/* logic/ook_pkg.sv */
// Purpose: Shared constants and types for the on-off-keyed baseband demodulator.
// Assumes: 200 MHz system clock, 8-bit strength samples.
// Notes:   Configuration travels as one packed struct.
package ook_pkg;

    localparam int          CLK_HZ          = 200_000_000;
    localparam int          RATE_STEP_HZ    = 100;
    localparam logic [8:0]  RATE_MIN        = 9'h001;
    localparam logic [8:0]  RATE_MAX        = 9'h190;
    localparam logic [8:0]  RATE_DEFAULT    = 9'h018;
    localparam logic [7:0]  ZERO_RUN_MIN    = 8'h04;
    localparam logic [7:0]  ZERO_RUN_DEF    = 8'h1f;
    localparam logic [7:0]  SQUELCH_DEF     = 8'h28;
    localparam int          ADC_BITS        = 8;
    localparam int          CAL_TIME_US     = 100;
    localparam int          CAL_CYCLES      = CAL_TIME_US * (CLK_HZ / 1_000_000);
    localparam int          AVG_SHIFT       = 4;
    localparam int          NOISE_SHIFT     = 6;

    typedef enum logic
    {
        METHOD_MIDDLE,
        METHOD_AVERAGE
    } demod_method_t;

    typedef struct packed
    {
        logic [8:0]    rate;
        demod_method_t method;
        logic [7:0]    zero_run;
        logic          squelch_en;
        logic [7:0]    squelch_margin;
        logic          agc_en;
    } ook_cfg_t;

    localparam ook_cfg_t CFG_DEFAULT = '{
        rate:           RATE_DEFAULT,
        method:         METHOD_MIDDLE,
        zero_run:       ZERO_RUN_DEF,
        squelch_en:     1'b0,
        squelch_margin: SQUELCH_DEF,
        agc_en:         1'b1
    };

endpackage : ook_pkg

/* logic/sar_adc_ctrl.sv */
// Purpose: Successive-approximation control for the 8-bit strength converter.
// Assumes: Comparator answer is valid one clock after the trial code changes.
// Notes:   One conversion costs two clocks per bit plus one.
`timescale 1ns/10ps
`default_nettype none
module sar_adc_ctrl
    import ook_pkg::*;
#(
    parameter int BITS = ADC_BITS
)
(
    input  wire logic            clk_sys,
    input  wire logic            nrst,
    input  wire logic            start,
    input  wire logic            cmp_high,
    output logic [BITS-1:0]      trial,
    output logic [BITS-1:0]      sample,
    output logic                 done
);

    typedef enum logic [1:0]
    {
        SAR_IDLE,
        SAR_SET,
        SAR_JUDGE
    } sar_state_t;

    sar_state_t          state;
    sar_state_t          next_state;
    logic [BITS-1:0]     bit_mask;
    logic [BITS-1:0]     next_bit_mask;
    logic [BITS-1:0]     next_trial;
    logic [BITS-1:0]     next_sample;
    logic                next_done;

    always_comb
    begin
        next_state    = state;
        next_bit_mask = bit_mask;
        next_trial    = trial;
        next_sample   = sample;
        next_done     = 1'b0;
        case (state)
            SAR_IDLE:
            begin
                if (start)
                begin
                    next_bit_mask = {1'b1, {(BITS-1){1'b0}}};
                    next_trial    = {1'b1, {(BITS-1){1'b0}}};
                    next_state    = SAR_SET;
                end
            end
            SAR_SET:
                // Wait one clock for the comparator to settle
                next_state = SAR_JUDGE;
            SAR_JUDGE:
            begin
                if (!cmp_high)
                    next_trial = trial & ~bit_mask;
                if (bit_mask[0])
                begin
                    next_sample = cmp_high ? trial : (trial & ~bit_mask);
                    next_done   = 1'b1;
                    next_state  = SAR_IDLE;
                end
                else
                begin
                    next_bit_mask = bit_mask >> 1;
                    next_trial    = (cmp_high ? trial : (trial & ~bit_mask)) | (bit_mask >> 1);
                    next_state    = SAR_SET;
                end
            end
            default:
                next_state = SAR_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            state    <= SAR_IDLE;
            bit_mask <= '0;
            trial    <= '0;
            sample   <= '0;
            done     <= 1'b0;
        end
        else
        begin
            state    <= next_state;
            bit_mask <= next_bit_mask;
            trial    <= next_trial;
            sample   <= next_sample;
            done     <= next_done;
        end
    end

endmodule : sar_adc_ctrl
`default_nettype wire

/* logic/ook_demod.sv */
// Purpose: Digital baseband of the on-off-keyed receiver: strength slicing to a data pin.
// Assumes: Configuration is loaded from nonvolatile memory before reset release.
// Notes:   Analogue front end, gain loop and programming protocol live outside.
`timescale 1ns/10ps
`default_nettype none
module ook_demod
    import ook_pkg::*;
#(
    parameter int CAL_COUNT = CAL_CYCLES
)
(
    input  wire logic                clk_sys,
    input  wire logic                nrst,
    input  wire ook_cfg_t            cfg,
    input  wire logic                prog_select_n,
    input  wire logic [ADC_BITS-2:0] rssi_i,
    input  wire logic [ADC_BITS-2:0] rssi_q,
    output logic                     cal_start,
    input  wire logic                cal_done,
    output logic                     agc_enable,
    output logic                     rx_active,
    output logic                     data_out
);

    // ------------------------------------------------------------
    // Types and state
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        ST_CAL,
        ST_RUN,
        ST_HOLD
    } top_state_t;

    top_state_t          state;
    top_state_t          next_state;
    logic [31:0]         cal_cnt;
    logic [31:0]         next_cal_cnt;
    ook_cfg_t            live_cfg;
    ook_cfg_t            next_live_cfg;
    logic [8:0]          rate_clamped;
    logic [31:0]         bit_period;
    logic [31:0]         bit_cnt;
    logic [31:0]         next_bit_cnt;
    logic                bit_tick;
    logic [ADC_BITS-1:0] rssi_sum;
    logic [ADC_BITS-1:0] trial;
    logic [ADC_BITS-1:0] sample;
    logic                sample_done;
    logic                cmp_high;
    logic [ADC_BITS-1:0] peak;
    logic [ADC_BITS-1:0] next_peak;
    logic [ADC_BITS-1:0] floor_lvl;
    logic [ADC_BITS-1:0] next_floor_lvl;
    logic [ADC_BITS+AVG_SHIFT-1:0]   avg_acc;
    logic [ADC_BITS+AVG_SHIFT-1:0]   next_avg_acc;
    logic [ADC_BITS+NOISE_SHIFT-1:0] noise_acc;
    logic [ADC_BITS+NOISE_SHIFT-1:0] next_noise_acc;
    logic [ADC_BITS-1:0] threshold;
    logic [ADC_BITS:0]   squelch_sum;
    logic [ADC_BITS-1:0] squelch_lvl;
    logic [7:0]          zero_cnt;
    logic [7:0]          next_zero_cnt;
    logic [7:0]          zero_limit;
    logic                next_data_out;
    logic                bit_val;

    // ------------------------------------------------------------
    // Strength conversion
    // ------------------------------------------------------------
    assign rssi_sum = {1'b0, rssi_i} + {1'b0, rssi_q};
    assign cmp_high = (rssi_sum >= trial);

    sar_adc_ctrl #(
        .BITS     (ADC_BITS)
    ) u_sar (
        .clk_sys  (clk_sys),
        .nrst     (nrst),
        .start    (state != ST_CAL),
        .cmp_high (cmp_high),
        .trial    (trial),
        .sample   (sample),
        .done     (sample_done)
    );

    // ------------------------------------------------------------
    // Bit clock
    // ------------------------------------------------------------
    always_comb
    begin
        rate_clamped = live_cfg.rate;
        if (rate_clamped < RATE_MIN)
            rate_clamped = RATE_MIN;
        else if (rate_clamped > RATE_MAX)
            rate_clamped = RATE_MAX;
        bit_period = 32'(CLK_HZ / RATE_STEP_HZ) / {23'h0, rate_clamped};
    end

    assign bit_tick = (state != ST_CAL) && (bit_cnt >= bit_period - 32'h1);
    assign next_bit_cnt = (state == ST_CAL || bit_tick) ? 32'h0 : bit_cnt + 32'h1;

    // ------------------------------------------------------------
    // Threshold and squelch
    // ------------------------------------------------------------
    assign zero_limit = (live_cfg.zero_run < ZERO_RUN_MIN) ? ZERO_RUN_MIN
                                                          : live_cfg.zero_run;

    always_comb
    begin
        next_peak      = peak;
        next_floor_lvl = floor_lvl;
        next_avg_acc   = avg_acc;
        next_noise_acc = noise_acc;
        if (sample_done)
        begin
            if (sample > peak)
                next_peak = sample;
            if (sample < floor_lvl)
                next_floor_lvl = sample;
            // Leaky averages trade settle time for noise immunity
            next_avg_acc = avg_acc - (avg_acc >> AVG_SHIFT) + {{AVG_SHIFT{1'b0}}, sample};
            if (sample < noise_acc[ADC_BITS+NOISE_SHIFT-1:NOISE_SHIFT])
                next_noise_acc = noise_acc - (noise_acc >> NOISE_SHIFT)
                                 + {{NOISE_SHIFT{1'b0}}, sample};
            else if (~&noise_acc)
                // Saturate so a loud idle channel cannot wrap to zero
                next_noise_acc = noise_acc + 1'b1;
        end
        // Long zero run: forget the peak so a faded link re-acquires
        if (bit_tick && zero_cnt >= zero_limit)
        begin
            next_peak      = sample;
            next_floor_lvl = sample;
        end
    end

    always_comb
    begin
        if (live_cfg.method == METHOD_AVERAGE)
            threshold = avg_acc[ADC_BITS+AVG_SHIFT-1:AVG_SHIFT];
        else
            threshold = ADC_BITS'(({1'b0, peak} + {1'b0, floor_lvl}) >> 1);
        squelch_sum = {1'b0, noise_acc[ADC_BITS+NOISE_SHIFT-1:NOISE_SHIFT]}
                      + {1'b0, live_cfg.squelch_margin};
        if (!live_cfg.squelch_en)
            squelch_lvl = '0;
        else if (squelch_sum[ADC_BITS])
            squelch_lvl = '1;
        else
            squelch_lvl = squelch_sum[ADC_BITS-1:0];
        bit_val = (sample > threshold) && (sample > squelch_lvl);
    end

    // ------------------------------------------------------------
    // Control and output
    // ------------------------------------------------------------
    always_comb
    begin
        next_state    = state;
        next_cal_cnt  = cal_cnt;
        next_live_cfg = live_cfg;
        next_zero_cnt = zero_cnt;
        next_data_out = data_out;
        case (state)
            ST_CAL:
            begin
                // Configuration follows cfg on every calibration clock; it cannot change mid-reception
                next_live_cfg = cfg;
                if (cal_cnt < 32'(CAL_COUNT))
                    next_cal_cnt = cal_cnt + 32'h1;
                else if (cal_done)
                    next_state = ST_RUN;
            end
            ST_RUN, ST_HOLD:
            begin
                // Programming traffic never steers reception
                next_state = prog_select_n ? ST_RUN : ST_HOLD;
                if (bit_tick)
                begin
                    next_data_out = bit_val;
                    if (bit_val || zero_cnt >= zero_limit)
                        next_zero_cnt = '0;
                    else
                        next_zero_cnt = zero_cnt + 8'h1;
                end
            end
            default:
                next_state = ST_CAL;
        endcase
    end

    assign cal_start  = (state == ST_CAL);
    assign rx_active  = (state != ST_CAL);
    assign agc_enable = live_cfg.agc_en;

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            state     <= ST_CAL;
            cal_cnt   <= '0;
            live_cfg  <= CFG_DEFAULT;
            bit_cnt   <= '0;
            peak      <= '0;
            floor_lvl <= '1;
            avg_acc   <= '0;
            noise_acc <= '0;
            zero_cnt  <= '0;
            data_out  <= 1'b0;
        end
        else
        begin
            state     <= next_state;
            cal_cnt   <= next_cal_cnt;
            live_cfg  <= next_live_cfg;
            bit_cnt   <= next_bit_cnt;
            peak      <= next_peak;
            floor_lvl <= next_floor_lvl;
            avg_acc   <= next_avg_acc;
            noise_acc <= next_noise_acc;
            zero_cnt  <= next_zero_cnt;
            data_out  <= next_data_out;
        end
    end

endmodule : ook_demod
`default_nettype wire

/* tb/ook_mcu_model.sv */
// Purpose: Behavioural microcontroller listening to the demodulated data pin.
// Assumes: Data pin is a push-pull level, sampled on the system clock.
// Notes:   Listens only; it never answers the receiver.
`timescale 1ns/10ps
`default_nettype none
module ook_mcu_model
(
    input  wire logic clk_sys,
    input  wire logic nrst,
    input  wire logic data_out,
    output logic      bit_seen,
    output int        edges
);
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            bit_seen <= 1'b0;
            edges    <= 0;
        end
        else
        begin
            bit_seen <= data_out;
            if (data_out !== bit_seen)
                edges <= edges + 1;
        end
    end
endmodule : ook_mcu_model
`default_nettype wire

/* tb/ook_demod_asserts.sv */
// Purpose: Port-level checks of the demodulator.
// Assumes: Bit rate stays fixed for a whole run.
// Notes:   Bound from the bench top.
`timescale 1ns/10ps
`default_nettype none
module ook_demod_checker
    import ook_pkg::*;
#(
    parameter int CAL_COUNT = CAL_CYCLES
)
(
    input wire logic                clk_sys,
    input wire logic                nrst,
    input wire ook_cfg_t            cfg,
    input wire logic                prog_select_n,
    input wire logic [ADC_BITS-2:0] rssi_i,
    input wire logic [ADC_BITS-2:0] rssi_q,
    input wire logic                cal_start,
    input wire logic                cal_done,
    input wire logic                agc_enable,
    input wire logic                rx_active,
    input wire logic                data_out
);
    int   cal_cnt;
    int   gap;
    logic gap_ok;

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            cal_cnt <= 0;
            gap     <= 0;
            gap_ok  <= 1'b0;
        end
        else
        begin
            if (!rx_active)
                cal_cnt <= cal_cnt + 1;
            gap    <= $changed(data_out) ? 1 : gap + 1;
            gap_ok <= gap_ok | $changed(data_out);
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);

    AST_CAL_MIN: assert property ($rose(rx_active) |-> cal_cnt >= CAL_COUNT)
        else $error("reception began before calibration time");
    AST_CAL_DONE: assert property ($rose(rx_active) |-> $past(cal_done))
        else $error("reception began without calibration done");
    AST_CAL_EXCL: assert property (cal_start != rx_active)
        else $error("calibrate and receive overlap");
    AST_RUN_KEEP: assert property (rx_active |=> rx_active)
        else $error("reception stopped without reset");
    AST_AGC_LATCH: assert property ($past(nrst) && $past(cal_start) |->
        agc_enable == $past(cfg.agc_en)) else $error("gain enable not taken from setting");
    AST_AGC_HOLD: assert property ($past(rx_active) |-> $stable(agc_enable))
        else $error("gain enable moved during reception");
    AST_DATA_IDLE: assert property (!rx_active |-> !data_out)
        else $error("data driven before reception");
    AST_DATA_TICK: assert property ($changed(data_out) && gap_ok && cfg.rate != 9'h000
        |-> gap % (2000000 / cfg.rate) == 0) else $error("data moved off the bit grid");

    cover property ($rose(rx_active));
    cover property ($rose(data_out));
    cover property (rx_active && !prog_select_n);
endmodule : ook_demod_checker
`default_nettype wire

/* tb/ook_demod_tb_top.sv */
// Purpose: Self-checking bench for the demodulator.
// Assumes: Top bit rate, so one bit lasts 5000 clocks.
// Notes:   Strength blocks span two bits to keep slicing unambiguous.
`timescale 1ns/10ps
`default_nettype none
module ook_demod_tb_top
    import ook_pkg::*;
;
    localparam int CAL_N = 10;
    logic                clk_sys;
    logic                nrst;
    logic                prog_select_n;
    logic                cal_done;
    ook_cfg_t            cfg;
    logic [ADC_BITS-2:0] rssi_i;
    logic [ADC_BITS-2:0] rssi_q;
    logic                cal_start;
    logic                agc_enable;
    logic                rx_active;
    logic                data_out;
    logic                mcu_bit;
    int                  mcu_edges;
    int                  err_total = 0;
    int                  cmp_count = 0;

    ook_demod #(.CAL_COUNT(CAL_N)) dut (.clk_sys(clk_sys), .nrst(nrst), .cfg(cfg),
        .prog_select_n(prog_select_n), .rssi_i(rssi_i), .rssi_q(rssi_q),
        .cal_start(cal_start), .cal_done(cal_done), .agc_enable(agc_enable),
        .rx_active(rx_active), .data_out(data_out));
    ook_mcu_model mcu (.clk_sys(clk_sys), .nrst(nrst), .data_out(data_out),
        .bit_seen(mcu_bit), .edges(mcu_edges));

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        #1;
        cmp_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic test_done();
        $display("Compares %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : test_done

    task automatic start_run(input ook_cfg_t c);
        @(posedge clk_sys);
        nrst          <= 1'b0;
        cfg           <= c;
        prog_select_n <= 1'b1;
        repeat (10) @(posedge clk_sys);
        nrst <= 1'b1;
        repeat (CAL_N) @(posedge clk_sys);
        check("rx_active early", rx_active, 1'b0);
    endtask : start_run

    task automatic wait_run();
        int n;
        n = 0;
        while (rx_active !== 1'b1 && n < 50)
        begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        if (n >= 50)
        begin
            err_total++;
            test_done();
        end
    endtask : wait_run

    // Each block lasts two bit periods
    task automatic blk(input logic [6:0] i, input logic [6:0] q);
        @(posedge clk_sys);
        rssi_i <= i;
        rssi_q <= q;
        repeat (10000) @(posedge clk_sys);
    endtask : blk

    initial
    begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    initial
    begin
        ook_cfg_t c;
        nrst          = 1'b0;
        cfg           = CFG_DEFAULT;
        prog_select_n = 1'b1;
        cal_done      = 1'b0;
        rssi_i        = 7'h00;
        rssi_q        = 7'h00;
        c             = CFG_DEFAULT;
        c.rate        = RATE_MAX;
        c.agc_en      = 1'b0;
        start_run(c);
        repeat (4) @(posedge clk_sys);
        check("cal_start held", cal_start, 1'b1);
        @(posedge clk_sys);
        cal_done <= 1'b1;
        wait_run();
        // High level only reaches 50 as the sum of both paths
        blk(7'h0a, 7'h0a);
        blk(7'h05, 7'h2d);
        check("data high", data_out, 1'b1);
        blk(7'h0a, 7'h0a);
        check("data low", data_out, 1'b0);
        @(posedge clk_sys);
        cfg.squelch_en <= 1'b1;
        cfg.agc_en     <= 1'b1;
        prog_select_n  <= 1'b0;
        blk(7'h05, 7'h2d);
        check("late cfg", data_out, 1'b1);
        check("agc off", agc_enable, 1'b0);
        check("still rx", rx_active, 1'b1);
        check("mcu edges", 8'(mcu_edges > 2), 8'h01);
        $display("Test default_run done");
        c.squelch_en = 1'b1;
        c.agc_en     = 1'b1;
        start_run(c);
        wait_run();
        check("agc on", agc_enable, 1'b1);
        blk(7'h0a, 7'h0a);
        blk(7'h05, 7'h2d);
        check("squelched", data_out, 1'b0);
        $display("Test squelch_run done");
        c.squelch_en = 1'b0;
        c.method     = METHOD_AVERAGE;
        start_run(c);
        wait_run();
        blk(7'h0a, 7'h0a);
        blk(7'h05, 7'h2d);
        check("average level", data_out, 1'b0);
        $display("Test average_run done");
        test_done();
    end
endmodule : ook_demod_tb_top

bind ook_demod ook_demod_checker #(.CAL_COUNT(CAL_COUNT)) checker_i (.clk_sys(clk_sys),
    .nrst(nrst), .cfg(cfg), .prog_select_n(prog_select_n), .rssi_i(rssi_i),
    .rssi_q(rssi_q), .cal_start(cal_start), .cal_done(cal_done),
    .agc_enable(agc_enable), .rx_active(rx_active), .data_out(data_out));
`default_nettype wire
